// >>> verilog/prioritized_interrupt_controller.sv
// Interrupt controller with priorities, sense control, transfer routing and an APB register file.
//
// The APB slave port and the placing of the registers were chosen for this implementation.

// Function
// RL1: Two control modes, chosen by a two-bit field in the system control register.
// RL2: Nonmaskable interrupt ranks at level 8 and is always accepted.
// RL3: Every source has its own distinct vector number.
// RL4: Nonmaskable input detects rising or falling edge, selected by configuration.
// RL5: Six external inputs each detect falling, rising, both edges, or low level.
// RL6: A request can start the data transfer unit instead of interrupting the CPU.
// RL7: Eleven priority registers, two 3-bit fields each at 6:4 and 2:0, reset to 7.
// RL8: Field value is the level directly, 000 lowest, 111 highest.
// RL9: Bits 7 and 3 of priority registers read as zero.
// RL10: Enable bits 0 to 5 gate external requests; reset to 0.
// RL11: Software writes only zeros to enable register bits 6 and 7.
// RL12: Sense code 00 low level, 01 falling, 10 rising, 11 both edges.
// RL13: Each input's status flag sets when its chosen trigger occurs.
// RL14: Highest priority pending request wins; ties go to the lower source number.
module prioritized_interrupt_controller (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [intc_pkg::ADDR_W-1:0] paddr,
   input wire logic [intc_pkg::DATA_W-1:0] pwdata,
   output logic [intc_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt pins and on-chip module requests.
   input wire logic nmi_pin,
   input wire logic [intc_pkg::NUM_IRQ-1:0] irq_pin_n,
   input wire logic [intc_pkg::NUM_MOD-1:0] module_req,
   // CPU side.
   input wire logic cpu_ibit,
   input wire logic [intc_pkg::PRI_W-1:0] cpu_mask_level,
   input wire logic cpu_ack,
   output logic cpu_req,
   output logic [intc_pkg::VEC_W-1:0] cpu_vector,
   output logic [intc_pkg::LEVEL_W-1:0] cpu_level,
   // Data transfer unit side.
   input wire logic xfer_ack,
   output logic xfer_req,
   output logic [intc_pkg::VEC_W-1:0] xfer_vector,
   // Event interrupt.
   output logic irq
);
   import intc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Highest priority requester; strict compare keeps the lowest index on ties.
   function automatic logic [SRC_IDX_W:0] pick_source(input logic [NUM_SRC-1:0] req,
                                                       input logic [NUM_SRC*PRI_W-1:0] pri);
      logic found;
      logic [SRC_IDX_W-1:0] idx;
      logic [PRI_W-1:0] best;
      found = 1'b0;
      idx = '0;
      best = '0;
      for (int s = 0; s < NUM_SRC; s++) begin
         if (req[s] && (!found || pri[s*PRI_W +: PRI_W] > best)) begin // RL14 RL8
            found = 1'b1;
            idx = SRC_IDX_W'(s);
            best = pri[s*PRI_W +: PRI_W];
         end
      end
      return {found, idx};
   endfunction : pick_source

   // Vector number of a source: external pins first, then module requests.
   function automatic logic [VEC_W-1:0] vector_of(input logic [SRC_IDX_W-1:0] s);
      if (s < SRC_IDX_W'(NUM_IRQ)) begin
         return VEC_IRQ_BASE + VEC_W'(s); // RL3
      end
      return VEC_MOD_BASE + VEC_W'(s - SRC_IDX_W'(NUM_IRQ)); // RL3
   endfunction : vector_of

   ////////////////////////////////////////////////////////////////////////////
   // State.

   logic [MODE_W-1:0] mode_q, mode_d;
   logic nmi_rise_q, nmi_rise_d;
   logic [NUM_IRQ*SENSE_W-1:0] sense_q, sense_d;
   logic [NUM_IRQ-1:0] enable_q, enable_d;
   logic [NUM_IRQ-1:0] flag_q, flag_d;
   logic nmi_flag_q, nmi_flag_d;
   logic [STATUS_W-1:0] evt_mask_q, evt_mask_d;
   logic [NUM_SRC-1:0] xfer_sel_q, xfer_sel_d;
   logic [NUM_SRC*PRI_W-1:0] pri_q, pri_d;
   logic cpu_req_q, cpu_req_d;
   logic cpu_nmi_q, cpu_nmi_d;
   logic [SRC_IDX_W-1:0] cpu_src_q, cpu_src_d;
   logic [VEC_W-1:0] cpu_vec_q, cpu_vec_d;
   logic [LEVEL_W-1:0] cpu_lvl_q, cpu_lvl_d;
   logic xfer_req_q, xfer_req_d;
   logic [SRC_IDX_W-1:0] xfer_src_q, xfer_src_d;
   logic [VEC_W-1:0] xfer_vec_q, xfer_vec_d;
   logic irq_q, irq_d;
   logic [DATA_W-1:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;

   logic [NUM_IRQ-1:0] irq_hit;
   logic nmi_hit;
   logic [NUM_SRC-1:0] pend;
   logic [SRC_IDX_W:0] cpu_pick;
   logic [SRC_IDX_W:0] xfer_pick;
   logic [PRI_W-1:0] cpu_best;
   logic cpu_accept;
   logic [STATUS_W-1:0] status_now;
   logic wr_go;
   logic [STATUS_W-1:0] w1c;
   logic hit_map;
   logic pri_hit;
   logic [ADDR_W-1:0] pri_ofs;
   logic [PRI_STRIDE_SHIFT+3:0] pri_idx_raw;
   int pri_idx;

   ////////////////////////////////////////////////////////////////////////////
   // Trigger detection.

   // One detector per external pin, each with its own sense code.
   for (genvar i = 0; i < NUM_IRQ; i++) begin : g_irq
      sense_detect #(.IDLE_LEVEL(1'b1)) u_det (
         .pclk(pclk),
         .presetn(presetn),
         .pin(irq_pin_n[i]),
         .sense(sense_q[i*SENSE_W +: SENSE_W]), // RL5 RL12
         .hit(irq_hit[i])
      );
   end

   // Nonmaskable pin uses the same detector, limited to one selected edge.
   sense_detect #(.IDLE_LEVEL(1'b1)) u_nmi_det (
      .pclk(pclk),
      .presetn(presetn),
      .pin(nmi_pin),
      .sense(nmi_rise_q ? SENSE_RISE : SENSE_FALL), // RL4
      .hit(nmi_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration.

   // Pending sources, split between the CPU path and the transfer path.
   always_comb begin
      pend = {module_req, flag_q & enable_q}; // RL10
      cpu_pick = pick_source(pend & ~xfer_sel_q, pri_q); // RL6
      xfer_pick = pick_source(pend & xfer_sel_q, pri_q); // RL6
      cpu_best = pri_q[cpu_pick[SRC_IDX_W-1:0]*PRI_W +: PRI_W];
      if (mode_q[MODE_HI_BIT]) begin
         cpu_accept = cpu_pick[SRC_IDX_W] && (cpu_best > cpu_mask_level); // RL1
      end else begin
         cpu_accept = cpu_pick[SRC_IDX_W] && !cpu_ibit; // RL1
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address decode.

   // Register hit and priority register index for the current address.
   always_comb begin
      pri_ofs = paddr - OFS_PRI_BASE;
      pri_idx_raw = pri_ofs[PRI_STRIDE_SHIFT+3+PRI_STRIDE_SHIFT:PRI_STRIDE_SHIFT];
      pri_idx = int'(pri_idx_raw);
      pri_hit = (paddr >= OFS_PRI_BASE) && (pri_ofs[PRI_STRIDE_SHIFT-1:0] == '0) &&
                (pri_ofs[ADDR_W-1:PRI_STRIDE_SHIFT+4+PRI_STRIDE_SHIFT] == '0) &&
                (pri_idx < NUM_PRI_REG);
      if (paddr == OFS_SYS_CTRL) begin
         hit_map = 1'b1;
      end else if (paddr == OFS_SENSE) begin
         hit_map = 1'b1;
      end else if (paddr == OFS_ENABLE) begin
         hit_map = 1'b1;
      end else if (paddr == OFS_STATUS) begin
         hit_map = 1'b1;
      end else if (paddr == OFS_EVT_MASK) begin
         hit_map = 1'b1;
      end else if (paddr == OFS_XFER_SEL) begin
         hit_map = 1'b1;
      end else if (paddr == OFS_VEC_VIEW) begin
         hit_map = 1'b1;
      end else begin
         hit_map = pri_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   // Register writes, flags, presented requests and bus answer.
   always_comb begin
      mode_d = mode_q;
      nmi_rise_d = nmi_rise_q;
      sense_d = sense_q;
      enable_d = enable_q;
      evt_mask_d = evt_mask_q;
      xfer_sel_d = xfer_sel_q;
      pri_d = pri_q;
      flag_d = flag_q;
      nmi_flag_d = nmi_flag_q;
      w1c = '0;
      wr_go = psel && penable && pready_q && pwrite;

      // Software writes take effect at the access edge.
      if (wr_go) begin
         if (paddr == OFS_SYS_CTRL) begin
            mode_d = pwdata[SYS_MODE_LSB +: MODE_W]; // RL1
            nmi_rise_d = pwdata[SYS_NMI_EDGE_BIT]; // RL4
         end else if (paddr == OFS_SENSE) begin
            sense_d = pwdata[NUM_IRQ*SENSE_W-1:0]; // RL12
         end else if (paddr == OFS_ENABLE) begin
            enable_d = pwdata[NUM_IRQ-1:0]; // RL10
         end else if (paddr == OFS_STATUS) begin
            w1c = pwdata[STATUS_W-1:0];
         end else if (paddr == OFS_EVT_MASK) begin
            evt_mask_d = pwdata[STATUS_W-1:0];
         end else if (paddr == OFS_XFER_SEL) begin
            xfer_sel_d = pwdata[NUM_SRC-1:0]; // RL6
         end else if (pri_hit) begin
            pri_d[(2*pri_idx)*PRI_W +: PRI_W] = pwdata[PRI_LOWER_LSB +: PRI_W]; // RL7
            pri_d[(2*pri_idx+1)*PRI_W +: PRI_W] = pwdata[PRI_UPPER_LSB +: PRI_W]; // RL7
         end
      end

      // Acknowledged edge sources drop their flag; a fresh trigger still wins.
      if (cpu_ack && cpu_req_q) begin
         if (cpu_nmi_q) begin
            w1c[STATUS_NMI_BIT] = 1'b1;
         end else if (cpu_src_q < SRC_IDX_W'(NUM_IRQ)) begin
            w1c[cpu_src_q[2:0]] = 1'b1;
         end
      end
      if (xfer_ack && xfer_req_q && xfer_src_q < SRC_IDX_W'(NUM_IRQ)) begin
         w1c[xfer_src_q[2:0]] = 1'b1;
      end
      flag_d = (flag_q & ~w1c[NUM_IRQ-1:0]) | irq_hit; // RL13
      nmi_flag_d = (nmi_flag_q & ~w1c[STATUS_NMI_BIT]) | nmi_hit; // RL2

      // Nonmaskable request overrides any maskable one at level 8.
      if (nmi_flag_q) begin
         cpu_req_d = 1'b1; // RL2
         cpu_nmi_d = 1'b1;
         cpu_src_d = '0;
         cpu_vec_d = VEC_NMI; // RL3
         cpu_lvl_d = NMI_LEVEL; // RL2
      end else begin
         cpu_req_d = cpu_accept; // RL14
         cpu_nmi_d = 1'b0;
         cpu_src_d = cpu_pick[SRC_IDX_W-1:0];
         cpu_vec_d = vector_of(cpu_pick[SRC_IDX_W-1:0]); // RL3
         cpu_lvl_d = LEVEL_W'(cpu_best); // RL8
      end
      xfer_req_d = xfer_pick[SRC_IDX_W]; // RL6
      xfer_src_d = xfer_pick[SRC_IDX_W-1:0];
      xfer_vec_d = vector_of(xfer_pick[SRC_IDX_W-1:0]);

      // Event interrupt from unmasked sticky flags.
      status_now = {nmi_flag_q, flag_q};
      irq_d = |(status_now & evt_mask_q);

      // Read data is captured in the setup cycle so the answer stands registered.
      pready_d = psel && !penable;
      pslverr_d = psel && !penable && !hit_map;
      prdata_d = '0;
      if (psel && !penable && !pwrite) begin
         if (paddr == OFS_SYS_CTRL) begin
            prdata_d[SYS_MODE_LSB +: MODE_W] = mode_q;
            prdata_d[SYS_NMI_EDGE_BIT] = nmi_rise_q;
         end else if (paddr == OFS_SENSE) begin
            prdata_d[NUM_IRQ*SENSE_W-1:0] = sense_q;
         end else if (paddr == OFS_ENABLE) begin
            prdata_d[NUM_IRQ-1:0] = enable_q;
         end else if (paddr == OFS_STATUS) begin
            prdata_d[STATUS_W-1:0] = status_now;
         end else if (paddr == OFS_EVT_MASK) begin
            prdata_d[STATUS_W-1:0] = evt_mask_q;
         end else if (paddr == OFS_XFER_SEL) begin
            prdata_d[NUM_SRC-1:0] = xfer_sel_q;
         end else if (paddr == OFS_VEC_VIEW) begin
            prdata_d[VIEW_REQ_BIT] = cpu_req_q;
            prdata_d[VEC_W-1:0] = cpu_vec_q;
         end else if (pri_hit) begin
            prdata_d[PRI_LOWER_LSB +: PRI_W] = pri_q[(2*pri_idx)*PRI_W +: PRI_W]; // RL9
            prdata_d[PRI_UPPER_LSB +: PRI_W] = pri_q[(2*pri_idx+1)*PRI_W +: PRI_W]; // RL9
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   // All state registered on every edge; reset gives mode 0 and priority 7.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= MODE_ZERO; // RL1
         nmi_rise_q <= 1'b0;
         sense_q <= '0;
         enable_q <= '0; // RL10
         flag_q <= '0;
         nmi_flag_q <= 1'b0;
         evt_mask_q <= '0;
         xfer_sel_q <= '0;
         pri_q <= {NUM_SRC{PRI_RESET}}; // RL7
         cpu_req_q <= 1'b0;
         cpu_nmi_q <= 1'b0;
         cpu_src_q <= '0;
         cpu_vec_q <= '0;
         cpu_lvl_q <= '0;
         xfer_req_q <= 1'b0;
         xfer_src_q <= '0;
         xfer_vec_q <= '0;
         irq_q <= 1'b0;
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         nmi_rise_q <= nmi_rise_d;
         sense_q <= sense_d;
         enable_q <= enable_d;
         flag_q <= flag_d;
         nmi_flag_q <= nmi_flag_d;
         evt_mask_q <= evt_mask_d;
         xfer_sel_q <= xfer_sel_d;
         pri_q <= pri_d;
         cpu_req_q <= cpu_req_d;
         cpu_nmi_q <= cpu_nmi_d;
         cpu_src_q <= cpu_src_d;
         cpu_vec_q <= cpu_vec_d;
         cpu_lvl_q <= cpu_lvl_d;
         xfer_req_q <= xfer_req_d;
         xfer_src_q <= xfer_src_d;
         xfer_vec_q <= xfer_vec_d;
         irq_q <= irq_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // Outputs straight from flip-flops.
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign cpu_req = cpu_req_q;
   assign cpu_vector = cpu_vec_q;
   assign cpu_level = cpu_lvl_q;
   assign xfer_req = xfer_req_q;
   assign xfer_vector = xfer_vec_q;
   assign irq = irq_q;

endmodule : prioritized_interrupt_controller

// >>> verilog/intc_pkg.sv
// Shared constants for the prioritized interrupt controller: map, fields, codes and vectors.
package intc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Source counts and widths.
   localparam int NUM_IRQ = 6;
   localparam int NUM_MOD = 16;
   localparam int NUM_SRC = NUM_IRQ + NUM_MOD;
   localparam int NUM_PRI_REG = 11;
   localparam int SRC_IDX_W = 5;
   localparam int PRI_W = 3;
   localparam int SENSE_W = 2;
   localparam int MODE_W = 2;
   localparam int VEC_W = 8;
   localparam int LEVEL_W = 4;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int STATUS_W = NUM_IRQ + 1;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFS_SYS_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_SENSE = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_XFER_SEL = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_VEC_VIEW = 12'h018;
   localparam logic [ADDR_W-1:0] OFS_PRI_BASE = 12'h020;
   localparam int PRI_STRIDE_SHIFT = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values.
   localparam int SYS_MODE_LSB = 4;
   localparam int SYS_NMI_EDGE_BIT = 3;
   localparam int MODE_HI_BIT = 1;
   localparam int PRI_LOWER_LSB = 0;
   localparam int PRI_UPPER_LSB = 4;
   localparam int STATUS_NMI_BIT = 6;
   localparam int VIEW_REQ_BIT = 8;
   localparam logic [PRI_W-1:0] PRI_RESET = 3'h7;
   localparam logic [MODE_W-1:0] MODE_ZERO = 2'h0;
   localparam logic [MODE_W-1:0] MODE_TWO = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Sense codes.
   localparam logic [SENSE_W-1:0] SENSE_LOW = 2'h0;
   localparam logic [SENSE_W-1:0] SENSE_FALL = 2'h1;
   localparam logic [SENSE_W-1:0] SENSE_RISE = 2'h2;
   localparam logic [SENSE_W-1:0] SENSE_BOTH = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Vector numbers and the nonmaskable level.
   localparam logic [VEC_W-1:0] VEC_NMI = 8'h07;
   localparam logic [VEC_W-1:0] VEC_IRQ_BASE = 8'h10;
   localparam logic [VEC_W-1:0] VEC_MOD_BASE = 8'h18;
   localparam logic [LEVEL_W-1:0] NMI_LEVEL = 4'h8;

endpackage : intc_pkg

// >>> verilog/sense_detect.sv
// Trigger detector for one interrupt pin: low level, falling, rising or both edges.
module sense_detect #(
   parameter logic IDLE_LEVEL = 1'b1
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Pin and selection.
   input wire logic pin,
   input wire logic [intc_pkg::SENSE_W-1:0] sense,
   output logic hit
);
   import intc_pkg::*;

   logic prev_q;
   logic prev_d;

   // Previous pin level for edge detection.
   always_comb begin
      prev_d = pin;
   end

   // Register the previous level; it starts at the idle level so reset makes no edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= IDLE_LEVEL;
      end else begin
         prev_q <= prev_d;
      end
   end

   // Trigger condition chosen by the sense code.
   always_comb begin
      case (sense)
         SENSE_LOW: hit = ~pin;
         SENSE_FALL: hit = prev_q & ~pin;
         SENSE_RISE: hit = ~prev_q & pin;
         default: hit = prev_q ^ pin;
      endcase
   end

endmodule : sense_detect

// >>> test/intc_props.sv
// Port checker for the prioritized interrupt controller.
module intc_props (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB answer.
   input wire logic psel,
   input wire logic penable,
   input wire logic [intc_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Requests.
   input wire logic cpu_ack,
   input wire logic cpu_req,
   input wire logic [intc_pkg::VEC_W-1:0] cpu_vector,
   input wire logic [intc_pkg::LEVEL_W-1:0] cpu_level,
   input wire logic xfer_req,
   input wire logic [intc_pkg::VEC_W-1:0] xfer_vector
);
   timeunit 1ns;
   timeprecision 1ps;
   import intc_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_nmi_taken;
      cpu_req && cpu_ack && cpu_vector == VEC_NMI;
   endsequence
   property p_setup_answer;
      s_setup |=> pready;
   endproperty
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   property p_err_zero;
      pslverr |-> pready && prdata == '0;
   endproperty
   property p_nmi_level;
      cpu_req && cpu_vector == VEC_NMI |-> cpu_level == NMI_LEVEL;
   endproperty
   property p_vec_map;
      cpu_req |-> cpu_vector == VEC_NMI || (cpu_vector >= VEC_IRQ_BASE && cpu_vector < VEC_MOD_BASE + NUM_MOD);
   endproperty
   property p_mask_level;
      cpu_req && cpu_vector != VEC_NMI |-> cpu_level < NMI_LEVEL;
   endproperty
   property p_xfer_vec;
      xfer_req |-> xfer_vector >= VEC_IRQ_BASE && xfer_vector < VEC_MOD_BASE + NUM_MOD;
   endproperty
   property p_nmi_drop;
      s_nmi_taken |=> ##1 !(cpu_req && cpu_vector == VEC_NMI);
   endproperty
   a_setup_answer: assert property (p_setup_answer) else $error("No answer after setup.");
   a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held too long.");
   a_err_zero: assert property (p_err_zero) else $error("Bad error answer.");
   a_nmi_level: assert property (p_nmi_level) else $error("Nonmaskable level wrong.");
   a_vec_map: assert property (p_vec_map) else $error("Vector out of map.");
   a_mask_level: assert property (p_mask_level) else $error("Maskable level too high.");
   a_xfer_vec: assert property (p_xfer_vec) else $error("Transfer vector out of map.");
   a_nmi_drop: assert property (p_nmi_drop) else $error("Nonmaskable request kept.");
endmodule : intc_props

bind prioritized_interrupt_controller intc_props chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_ack(cpu_ack),
   .cpu_req(cpu_req), .cpu_vector(cpu_vector), .cpu_level(cpu_level), .xfer_req(xfer_req),
   .xfer_vector(xfer_vector));

// >>> test/cpu_partner.sv
// Behavioural CPU core and transfer unit that take requests from the controller.
module cpu_partner (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Requests and answer delay.
   input wire logic cpu_req,
   input wire logic [intc_pkg::VEC_W-1:0] cpu_vector,
   input wire logic [intc_pkg::LEVEL_W-1:0] cpu_level,
   input wire logic xfer_req,
   input wire logic [intc_pkg::VEC_W-1:0] xfer_vector,
   input wire logic [3:0] delay,
   // Acceptance pulses.
   output logic cpu_ack,
   output logic xfer_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] log_q[$];
   logic [7:0] xlog_q[$];
   initial begin
      cpu_ack = 1'b0;
      xfer_ack = 1'b0;
   end
   // The core accepts once after the delay, then lets the old request drain.
   always begin
      @(posedge pclk);
      if (presetn === 1'b1 && cpu_req === 1'b1) begin
         repeat (delay) @(posedge pclk);
         log_q.push_back({cpu_level, cpu_vector});
         cpu_ack <= 1'b1;
         @(posedge pclk);
         cpu_ack <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   end
   // The transfer unit takes its request promptly.
   always begin
      @(posedge pclk);
      if (presetn === 1'b1 && xfer_req === 1'b1) begin
         xlog_q.push_back(xfer_vector);
         xfer_ack <= 1'b1;
         @(posedge pclk);
         xfer_ack <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   end
endmodule : cpu_partner

// >>> test/test_prioritized_interrupt_controller.sv
// Self-checking bench for the prioritized interrupt controller.
module test_prioritized_interrupt_controller;
   timeunit 1ns;
   timeprecision 1ps;
   import intc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, cpu_req, xfer_req, irq, cpu_ack, xfer_ack;
   logic nmi_pin = 1, cpu_ibit = 1;
   logic [NUM_IRQ-1:0] irq_pin_n = '1;
   logic [NUM_MOD-1:0] module_req = '0;
   logic [PRI_W-1:0] cpu_mask_level = '0;
   logic [VEC_W-1:0] cpu_vector, xfer_vector;
   logic [LEVEL_W-1:0] cpu_level;
   logic [3:0] delay = 4'hF;
   int error_cnt = 0, cmp_count = 0;
   initial forever #2 pclk = ~pclk;
   prioritized_interrupt_controller dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .nmi_pin, .irq_pin_n, .module_req, .cpu_ibit, .cpu_mask_level,
      .cpu_ack, .cpu_req, .cpu_vector, .cpu_level, .xfer_ack, .xfer_req, .xfer_vector, .irq);
   cpu_partner cpu (.pclk, .presetn, .cpu_req, .cpu_vector, .cpu_level, .xfer_req, .xfer_vector,
      .delay, .cpu_ack, .xfer_ack);
   ////////////////////
   task automatic report_and_stop;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   // One APB transfer; the request holds until pready is sampled high.
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) begin
         chk("apb answer", 1, 0);
         report_and_stop();
      end
   endtask : apb
   task automatic rdc(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      apb(1'b0, a, '0);
      chk(name, exp, rd);
   endtask : rdc
   task automatic wait_q(input int n);
      int i;
      for (i = 0; i < 200 && cpu.log_q.size() < n; i++) @(posedge pclk);
      chk("request count", n, cpu.log_q.size());
      if (i == 200) report_and_stop();
   endtask : wait_q
   ////////////////////
   task automatic t_regs;
      for (int r = 0; r < NUM_PRI_REG; r++) rdc("priority reset", OFS_PRI_BASE + 12'(r * 4), 32'h0000_0077);
      rdc("enable reset", OFS_ENABLE, 32'h0000_0000);
      rdc("mode reset", OFS_SYS_CTRL, 32'h0000_0000);
      apb(1'b1, OFS_PRI_BASE + 12'h008, 32'h0000_00FF);
      rdc("reserved bits", OFS_PRI_BASE + 12'h008, 32'h0000_0077);
      apb(1'b1, OFS_PRI_BASE + 12'h008, 32'h0000_0013);
      rdc("priority fields", OFS_PRI_BASE + 12'h008, 32'h0000_0013);
      apb(1'b1, OFS_SYS_CTRL, 32'h0000_0020);
      rdc("mode field", OFS_SYS_CTRL, 32'h0000_0020);
      apb(1'b1, OFS_SYS_CTRL, 32'h0000_0000);
      rdc("unmapped data", 12'h0FC, 32'h0000_0000);
      chk("unmapped error", 1, err);
      $display("t_regs done");
   endtask : t_regs
   // Each sense code on its own pin: flags after a fall, then after a rise.
   task automatic t_sense;
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, OFS_SENSE, 32'(c) << (2 * c));
         apb(1'b1, OFS_STATUS, 32'h0000_007F);
         irq_pin_n[c] <= 1'b0;
         cyc(3);
         rdc("fall flag", OFS_STATUS, 32'(c != 2) << c);
         apb(1'b1, OFS_STATUS, 32'h0000_007F);
         irq_pin_n[c] <= 1'b1;
         cyc(3);
         rdc("rise flag", OFS_STATUS, 32'(c != 1) << c);
      end
      $display("t_sense done");
   endtask : t_sense
   // Nonmaskable pin on each edge setting, with the I bit set.
   task automatic t_nmi;
      for (int e = 0; e < 2; e++) begin
         apb(1'b1, OFS_SYS_CTRL, 32'(e) << SYS_NMI_EDGE_BIT);
         nmi_pin <= 1'b0;
         cyc(30);
         nmi_pin <= 1'b1;
         cyc(2);
         if (e) rdc("nmi view", OFS_VEC_VIEW, 32'h0000_0107);
         wait_q(1);
         chk("nmi vector", {NMI_LEVEL, VEC_NMI}, cpu.log_q.pop_front());
         cyc(30);
         chk("nmi single", 0, cpu.log_q.size());
      end
      $display("t_nmi done");
   endtask : t_nmi
   // Pins 0 to 2 fall together; pin 2 stays disabled.
   task automatic pair(input logic [31:0] pri, input logic [11:0] first, second, input logic held);
      apb(1'b1, OFS_PRI_BASE, pri);
      irq_pin_n <= 6'h38;
      cyc(2);
      irq_pin_n <= '1;
      cyc(30);
      if (held) begin
         chk("held back", 0, cpu.log_q.size());
         cpu_ibit <= 1'b0;
         cpu_mask_level <= 3'h1;
      end
      wait_q(2);
      chk("first winner", first, cpu.log_q.pop_front());
      chk("second winner", second, cpu.log_q.pop_front());
      cyc(30);
      chk("disabled pin", 0, cpu.log_q.size());
   endtask : pair
   task automatic t_prio;
      apb(1'b1, OFS_SENSE, 32'h0000_0555);
      apb(1'b1, OFS_ENABLE, 32'h0000_0003);
      pair(32'h0000_0052, 12'h511, 12'h210, 1'b1);
      pair(32'h0000_0044, 12'h410, 12'h411, 1'b0);
      apb(1'b1, OFS_SYS_CTRL, 32'h0000_0020);
      cpu_mask_level <= 3'h5;
      pair(32'h0000_0052, 12'h511, 12'h210, 1'b1);
      apb(1'b1, OFS_SYS_CTRL, 32'h0000_0000);
      $display("t_prio done");
   endtask : t_prio
   task automatic t_xfer;
      apb(1'b1, OFS_XFER_SEL, 32'h0000_0001);
      apb(1'b1, OFS_ENABLE, 32'h0000_0001);
      irq_pin_n[0] <= 1'b0;
      cyc(2);
      irq_pin_n[0] <= 1'b1;
      cyc(20);
      chk("xfer count", 1, cpu.xlog_q.size());
      chk("xfer vector", VEC_IRQ_BASE, cpu.xlog_q.pop_front());
      chk("cpu untouched", 0, cpu.log_q.size());
      apb(1'b1, OFS_XFER_SEL, 32'h0000_0000);
      $display("t_xfer done");
   endtask : t_xfer
   // Event line raised, masked, unmasked and cleared.
   task automatic t_irq;
      apb(1'b1, OFS_ENABLE, 32'h0000_0000);
      apb(1'b1, OFS_EVT_MASK, 32'h0000_0001);
      irq_pin_n[0] <= 1'b0;
      cyc(2);
      irq_pin_n[0] <= 1'b1;
      cyc(3);
      chk("irq raised", 1, irq);
      apb(1'b1, OFS_EVT_MASK, 32'h0000_0000);
      cyc(2);
      chk("irq masked", 0, irq);
      apb(1'b1, OFS_EVT_MASK, 32'h0000_0001);
      cyc(2);
      chk("irq unmasked", 1, irq);
      apb(1'b1, OFS_STATUS, 32'h0000_007F);
      cyc(2);
      chk("irq cleared", 0, irq);
      module_req[0] <= 1'b1;
      cyc(2);
      chk("module vector", VEC_MOD_BASE, cpu_vector);
      $display("t_irq done");
   endtask : t_irq
   // Main sequence.
   initial begin
      cyc(8);
      presetn <= 1'b1;
      t_regs();
      t_sense();
      t_nmi();
      t_prio();
      t_xfer();
      t_irq();
      report_and_stop();
   end
endmodule : test_prioritized_interrupt_controller
